//--- include/cac_pkg.sv
// Constants, types and helpers for the accumulator/file instruction subset core
package cac_pkg;

  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned BANK_W  = 4;

  // Opcode fields, taken from the top of the program word
  localparam logic [5:0] OPC_ADD_CARRY = 6'h08;   // 0010_00 d a
  localparam logic [7:0] OPC_AND_LIT   = 8'h0B;   // 0000_1011
  localparam logic [7:0] OPC_LOAD_LIT  = 8'h0E;   // 0000_1110
  localparam logic [6:0] OPC_STORE     = 7'h37;   // 0110_111 a

  // Field positions within the program word
  localparam int unsigned DEST_BIT   = 9;
  localparam int unsigned ACCESS_BIT = 8;

  // Access bank split and indexed literal-offset limit
  localparam logic [7:0] LIT_OFS_MAX   = 8'h5F;
  localparam logic [3:0] ACCESS_LO_BNK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BNK = 4'hF;

  // Nibble-carry tap and sign position
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned SIGN_BIT = 7;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {OP_NONE, OP_ADD, OP_AND, OP_LOAD, OP_STORE} cac_op_t;

  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic dcarry;
    logic carry;
  } cac_status_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cac_mem_req_t;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam cac_status_t       STATUS_RST = '0;
  localparam logic [ADDR_W-1:0] ADDR_RST   = 12'h000;
  localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;

  // ****************************************
  // Helpers
  // ****************************************
  // Map a program word onto one of the supported operations
  function automatic cac_op_t decode_op(input logic [INSTR_W-1:0] w);
    cac_op_t op;
    op = OP_NONE;
    if (w[15:10] == OPC_ADD_CARRY)
      op = OP_ADD;
    else if (w[15:8] == OPC_AND_LIT)
      op = OP_AND;
    else if (w[15:8] == OPC_LOAD_LIT)
      op = OP_LOAD;
    else if (w[15:9] == OPC_STORE)
      op = OP_STORE;
    return op;
  endfunction

  // Zero flag of a byte result
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return (v == '0);
  endfunction

endpackage

//--- src/cac_exec_unit.sv
// Data processing stage: adder, AND unit and flag generation
`timescale 1ns/100ps
module cac_exec_unit
  import cac_pkg::*;
(
  input  wire cac_pkg::cac_op_t     op_i,
  input  wire logic [7:0]           acc_i,
  input  wire logic [7:0]           file_i,
  input  wire logic [7:0]           literal_i,
  input  wire cac_pkg::cac_status_t status_i,
  output cac_pkg::cac_status_t      status_o,
  output logic [7:0]                result_o
);
  import cac_pkg::*;

  logic [DATA_W:0]  sum9;
  logic [NIB_W:0]   sum_nib;

  // ****************************************
  // Sum of accumulator, file and carry
  // ****************************************
  always_comb
  begin
    sum9    = {1'b0, acc_i} + {1'b0, file_i} + {{DATA_W{1'b0}}, status_i.carry};
    sum_nib = {1'b0, acc_i[NIB_W-1:0]} + {1'b0, file_i[NIB_W-1:0]} + {{NIB_W{1'b0}}, status_i.carry};
  end

  // Result and flag selection per operation
  always_comb
  begin
    result_o = acc_i;
    status_o = status_i;
    case (op_i)
      OP_ADD:
      begin
        result_o        = sum9[DATA_W-1:0];                                  // [RQ1]
        status_o.carry  = sum9[DATA_W];
        status_o.dcarry = sum_nib[NIB_W];
        status_o.zero   = is_zero(sum9[DATA_W-1:0]);
        status_o.neg    = sum9[SIGN_BIT];
        status_o.ovf    = (acc_i[SIGN_BIT] == file_i[SIGN_BIT]) && (sum9[SIGN_BIT] != acc_i[SIGN_BIT]);
      end
      OP_AND:
      begin
        result_o      = acc_i & literal_i;                                   // [RQ9]
        status_o.zero = is_zero(acc_i & literal_i);                          // [RQ9]
        status_o.neg  = acc_i[SIGN_BIT] & literal_i[SIGN_BIT];               // [RQ9]
      end
      OP_LOAD:
        result_o = literal_i;                                                // [RQ6]
      OP_STORE:
        result_o = acc_i;                                                    // [RQ7]
      default:
        result_o = acc_i;
    endcase
  end

endmodule

//--- src/cac_core.sv
// Four-phase executor for add-with-carry, AND literal, load literal and store
`timescale 1ns/100ps

// Summary of operation
// RQ1: Add accumulator, file register and carry
// RQ2: Destination bit 0 accumulator, 1 file
// RQ3: Access bit 0 uses access bank
// RQ4: Access bit 1 takes bank pointer bits
// RQ5: Extended set, low operand is indexed offset
// RQ6: Load literal into accumulator, flags kept
// RQ7: Store accumulator to file, nothing else changes
// RQ8: Store operand reaches whole 256-byte bank
// RQ9: AND literal, update negative and zero
// RQ10: One word, four phases per instruction
module cac_core
  import cac_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  input  wire logic                 ce_i,
  input  wire logic                 instr_valid_i,
  input  wire logic [15:0]          instr_i,
  output logic                      instr_ready_o,
  input  wire logic [3:0]           bank_select_pointer_i,
  input  wire logic                 ext_set_en_i,
  input  wire logic [11:0]          index_base_i,
  input  wire logic [7:0]           mem_rdata_i,
  output logic                      mem_rd_o,
  output logic                      mem_wr_o,
  output cac_pkg::cac_mem_req_t     mem_req_o,
  output logic [7:0]                acc_o,
  output cac_pkg::cac_status_t      status_o,
  output logic                      done_o,
  output logic                      illegal_o
);
  import cac_pkg::*;

  // ****************************************
  // Phase sequencer
  // ****************************************
  typedef enum logic [2:0] {ST_IDLE, ST_DECODE, ST_READ, ST_PROCESS, ST_WRITE} cac_state_t;

  cac_state_t          state_r;
  cac_state_t          state_nxt;
  logic [15:0]         instr_r;
  logic [15:0]         instr_nxt;
  cac_op_t             op_r;
  cac_op_t             op_nxt;
  logic                to_file_r;
  logic                to_file_nxt;
  cac_mem_req_t        req_r;
  cac_mem_req_t        req_nxt;
  logic [7:0]          acc_r;
  logic [7:0]          acc_nxt;
  cac_status_t         status_r;
  cac_status_t         status_nxt;
  logic [7:0]          res_r;
  logic [7:0]          res_nxt;
  cac_status_t         pend_r;
  cac_status_t         pend_nxt;
  logic                illegal_r;
  logic                illegal_nxt;

  logic [7:0]          ex_result;
  cac_status_t         ex_status;
  logic [7:0]          f_field;
  logic                access_a;
  logic [11:0]         eff_addr;

  // Operand fields of the latched word
  assign f_field  = instr_r[7:0];
  assign access_a = instr_r[ACCESS_BIT];

  // Effective data memory address of the file operand
  always_comb
  begin
    if (!access_a && ext_set_en_i && (f_field <= LIT_OFS_MAX))
      eff_addr = 12'(index_base_i + {ACCESS_LO_BNK, f_field});              // [RQ5]
    else if (!access_a && (f_field <= LIT_OFS_MAX))
      eff_addr = {ACCESS_LO_BNK, f_field};                                   // [RQ3]
    else if (!access_a)
      eff_addr = {ACCESS_HI_BNK, f_field};                                   // [RQ3]
    else
      eff_addr = {bank_select_pointer_i, f_field};                           // [RQ4] [RQ8]
  end

  // Data processing unit
  cac_exec_unit u_exec (
    .op_i      (op_r),
    .acc_i     (acc_r),
    .file_i    (mem_rdata_i),
    .literal_i (f_field),
    .status_i  (status_r),
    .status_o  (ex_status),
    .result_o  (ex_result)
  );

  // Sequencer next state: latch, decode and step through the phases
  always_comb
  begin
    state_nxt   = state_r;
    instr_nxt   = instr_r;
    op_nxt      = op_r;
    to_file_nxt = to_file_r;
    illegal_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
        if (instr_valid_i)
        begin
          instr_nxt = instr_i;                                               // [RQ10]
          state_nxt = ST_DECODE;
        end
      // Q1: decode; unsupported words are dropped here
      ST_DECODE:
      begin
        op_nxt      = decode_op(instr_r);
        to_file_nxt = (decode_op(instr_r) == OP_STORE) ||
                      ((decode_op(instr_r) == OP_ADD) && instr_r[DEST_BIT]); // [RQ2] [RQ7]
        if (decode_op(instr_r) == OP_NONE)
        begin
          illegal_nxt = 1'b1;
          state_nxt   = ST_IDLE;
        end
        else
          state_nxt = ST_READ;
      end
      // Q2: file read issued for the add
      ST_READ:
        state_nxt = ST_PROCESS;
      // Q3: data processing
      ST_PROCESS:
        state_nxt = ST_WRITE;
      // Q4: commit, then back to idle
      ST_WRITE:
        state_nxt = ST_IDLE;                                                 // [RQ10]
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer registers, frozen while the clock enable is low
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r   <= ST_IDLE;
      instr_r   <= INSTR_RST;
      op_r      <= OP_NONE;
      to_file_r <= 1'b0;
      illegal_r <= 1'b0;
    end
    else if (ce_i)
    begin
      state_r   <= state_nxt;
      instr_r   <= instr_nxt;
      op_r      <= op_nxt;
      to_file_r <= to_file_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  // Datapath next values, stepped by the sequencer phase
  always_comb
  begin
    req_nxt    = req_r;
    acc_nxt    = acc_r;
    status_nxt = status_r;
    res_nxt    = res_r;
    pend_nxt   = pend_r;
    case (state_r)
      // Q1: operand address held for the read and the write
      ST_DECODE:
        req_nxt.addr = eff_addr;                                             // [RQ3] [RQ4] [RQ5]
      // Q3: result and pending flags, write data follows the result
      ST_PROCESS:
      begin
        res_nxt       = ex_result;
        pend_nxt      = ex_status;
        req_nxt.wdata = ex_result;
      end
      // Q4: destination and flags commit together
      ST_WRITE:
      begin
        if (!to_file_r)
          acc_nxt = res_r;                                                   // [RQ2] [RQ6] [RQ9]
        status_nxt = pend_r;                                                 // [RQ1] [RQ9]
      end
      default:
        res_nxt = res_r;
    endcase
  end

  // Datapath registers, frozen while the clock enable is low
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      req_r    <= '{addr: ADDR_RST, wdata: ACC_RST};
      acc_r    <= ACC_RST;
      status_r <= STATUS_RST;
      res_r    <= ACC_RST;
      pend_r   <= STATUS_RST;
    end
    else if (ce_i)
    begin
      req_r    <= req_nxt;
      acc_r    <= acc_nxt;
      status_r <= status_nxt;
      res_r    <= res_nxt;
      pend_r   <= pend_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Read, write and done strobes gated by the clock enable; ready is not
  assign instr_ready_o = (state_r == ST_IDLE);
  assign mem_rd_o      = ce_i && (state_r == ST_READ) && (op_r == OP_ADD);  // [RQ1]
  assign mem_wr_o      = ce_i && (state_r == ST_WRITE) && to_file_r;         // [RQ2] [RQ7]
  assign done_o        = ce_i && (state_r == ST_WRITE);

  // Registered data outputs
  assign mem_req_o = req_r;
  assign acc_o     = acc_r;
  assign status_o  = status_r;
  assign illegal_o = illegal_r;

endmodule

//--- tb/cac_core_checker.sv
// Port-level timing and result checks for the core
`timescale 1ns/100ps
module cac_core_checker
  import cac_pkg::*;
(
  input wire logic                  mclk_i,
  input wire logic                  reset_i,
  input wire logic                  ce_i,
  input wire logic                  instr_valid_i,
  input wire logic [15:0]           instr_i,
  input wire logic                  instr_ready_o,
  input wire logic [3:0]            bank_select_pointer_i,
  input wire logic                  ext_set_en_i,
  input wire logic [11:0]           index_base_i,
  input wire logic [7:0]            mem_rdata_i,
  input wire logic                  mem_rd_o,
  input wire logic                  mem_wr_o,
  input wire cac_pkg::cac_mem_req_t mem_req_o,
  input wire logic [7:0]            acc_o,
  input wire cac_pkg::cac_status_t  status_o,
  input wire logic                  done_o,
  input wire logic                  illegal_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Accepted words by kind
  wire tk = ce_i & instr_ready_o & instr_valid_i;
  wire ad = tk & (instr_i[15:10] == OPC_ADD_CARRY);
  wire an = tk & (instr_i[15:8] == OPC_AND_LIT);
  wire ld = tk & (instr_i[15:8] == OPC_LOAD_LIT);
  wire st = tk & (instr_i[15:9] == OPC_STORE);
  wire [7:0] f = instr_i[7:0];
  wire lo = ~instr_i[8] & (f <= LIT_OFS_MAX);

  property p_sum;
    ad & ~instr_i[9] |-> ##5 acc_o == 8'($past(acc_o, 5) + $past(mem_rdata_i, 2) + $past(status_o.carry, 5));
  endproperty
  a_sum: assert property (p_sum) else $error("add result wrong");
  property p_dest;
    ad |-> ##4 done_o && mem_wr_o == $past(instr_i[9], 4);
  endproperty
  a_dest: assert property (p_dest) else $error("add destination wrong");
  property p_acc_bank;
    ad & ~instr_i[8] & ~lo |-> ##2 mem_rd_o && mem_req_o.addr == {ACCESS_HI_BNK, $past(f, 2)};
  endproperty
  a_acc_bank: assert property (p_acc_bank) else $error("access bank address wrong");
  property p_bank;
    ad & instr_i[8] |-> ##2 mem_req_o.addr == {$past(bank_select_pointer_i, 2), $past(f, 2)};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_index;
    ad & lo & ext_set_en_i |-> ##2 mem_req_o.addr == 12'($past(index_base_i, 2) + $past(f, 2));
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");
  property p_load;
    ld |-> ##5 acc_o == $past(f, 5) && status_o == $past(status_o, 5);
  endproperty
  a_load: assert property (p_load) else $error("load result wrong");
  property p_store;
    st |-> ##4 mem_wr_o && mem_req_o.wdata == acc_o ##1 acc_o == $past(acc_o, 5) && status_o == $past(status_o, 5);
  endproperty
  a_store: assert property (p_store) else $error("store wrong");
  property p_and;
    an |-> ##5 acc_o == ($past(acc_o, 5) & $past(f, 5)) && status_o.carry == $past(status_o.carry, 5);
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");
  property p_frame;
    ad | an | ld | st |=> (!instr_ready_o && !done_o)[*3] ##1 (done_o && !instr_ready_o) ##1 instr_ready_o;
  endproperty
  a_frame: assert property (p_frame) else $error("instruction framing wrong");
endmodule

bind cac_core cac_core_checker u_chk (.*);

//--- tb/testbench.sv
// Self-checking bench for the instruction subset core
`timescale 1ns/100ps
module testbench;
  import cac_pkg::*;
  logic mclk_i = 0, reset_i = 1, ce_i = 1, instr_valid_i = 0, ext_set_en_i = 0;
  logic [15:0] instr_i = 0;
  logic [3:0] bank_select_pointer_i = 0;
  logic [11:0] index_base_i = 0;
  logic [7:0] mem_rdata_i = 0, m_acc = 0;
  logic instr_ready_o, mem_rd_o, mem_wr_o, done_o, illegal_o;
  cac_mem_req_t mem_req_o;
  logic [7:0] acc_o;
  cac_status_t status_o;
  logic [4:0] m_st = 0;
  logic [7:0] cf [4] = '{8'h5F, 8'h60, 8'h00, 8'hFF};
  int mismatches = 0, total_checks = 0, k, seed = 32'h5291_8968;

  cac_core u_dut (.*);

  // Clock
  always #4 mclk_i = ~mclk_i;

  // Compare and count
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", n, exp, seen);
    end
  endtask

  // Verdict
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Expected file address
  function automatic logic [11:0] addr_of(input logic a, input logic [7:0] f);
    if (a)
      return {bank_select_pointer_i, f};
    if (f > LIT_OFS_MAX)
      return {ACCESS_HI_BNK, f};
    return ext_set_en_i ? index_base_i + 12'(f) : {ACCESS_LO_BNK, f};
  endfunction

  // One instruction, kind t: add, and, load, store, bad
  task automatic ex(input int t, input logic d, input logic a, input logic [7:0] f);
    logic [7:0] v, r;
    logic [8:0] s;
    logic [4:0] h;
    logic [11:0] e;
    v = 8'($random(seed));
    @(negedge mclk_i);
    bank_select_pointer_i = 4'($random(seed));
    ext_set_en_i = 1'($random(seed));
    index_base_i = 12'($random(seed));
    instr_i = t == 0 ? {OPC_ADD_CARRY, d, a, f} : t == 1 ? {OPC_AND_LIT, f} : t == 2 ? {OPC_LOAD_LIT, f}
            : t == 3 ? {OPC_STORE, a, f} : 16'hFFFF;
    instr_valid_i = 1;
    e = addr_of(a, f);
    chk("ready", instr_ready_o, 1); // Idle
    @(negedge mclk_i);
    instr_valid_i = 0;
    instr_i = 16'($random(seed));
    @(negedge mclk_i);
    if (t == 4)
    begin
      chk("illegal", illegal_o, 1); // Unsupported word dropped
      chk("ill_rdy", instr_ready_o, 1); // Back to idle
    end
    else
    begin
      chk("rd", mem_rd_o, 16'(t == 0)); // Read only on add
      chk("busy", instr_ready_o, 0); // No take while busy
      chk("no_ill", illegal_o, 0); // Supported word
      chk("early", done_o, 0); // Not yet committed
      if (t == 0) chk("addr", mem_req_o.addr, e); // Address
      @(negedge mclk_i);
      mem_rdata_i = v;
      @(negedge mclk_i);
      mem_rdata_i = ~v;
      s = m_acc + v + m_st[0];
      h = m_acc[3:0] + v[3:0] + m_st[0];
      r = t == 0 ? s[7:0] : t == 1 ? m_acc & f : t == 2 ? f : m_acc;
      chk("done", done_o, 1); // Commit
      chk("wr", mem_wr_o, 16'(t == 3 || (t == 0 && d))); // Dest
      if (t == 3 || (t == 0 && d)) chk("wdata", mem_req_o.wdata, r); // Data
      if (t == 3) chk("saddr", mem_req_o.addr, e); // Any offset
      if (t == 0) m_st = {r[7], ((m_acc[7] == v[7]) && (s[7] != m_acc[7])), r == 0, h[4], s[8]};
      if (t == 1) m_st = {r[7], m_st[3], r == 0, m_st[1:0]};
      if (t == 1 || t == 2 || (t == 0 && !d)) m_acc = r;
    end
    @(negedge mclk_i);
    chk("acc", acc_o, m_acc); // Acc
    chk("flags", status_o, m_st); // Flags
  endtask

  // Main sequence: corners first, then random mix
  initial
  begin
    repeat (4) @(negedge mclk_i);
    reset_i = 0;
    chk("rst_acc", acc_o, 0); // Reset state
    chk("rst_flags", status_o, 0); // Reset state
    // Clock enable low: a presented word must not be taken
    ce_i = 0;
    instr_valid_i = 1;
    instr_i = {OPC_LOAD_LIT, 8'hA5};
    repeat (3) @(negedge mclk_i);
    chk("frozen", acc_o, 0); // Nothing loaded while frozen
    chk("frz_rdy", instr_ready_o, 1); // Still idle
    instr_valid_i = 0;
    ce_i = 1;
    for (k = 0; k < 300; k++)
      ex(k < 5 ? k : $unsigned($random(seed)) % 5, 1'($random(seed)), k > 8 ? 1'($random(seed)) : k[0],
         k < 16 ? cf[k % 4] : 8'($random(seed)));
    final_report;
  end

  // Watchdog
  initial
  begin
    #100000;
    mismatches++;
    final_report;
  end
endmodule
